// ---- design/oms_pkg.sv ----
// Operation
// - startup selection accepts codes 0, 1 and 10; default is 0
// - initial mode comes from mode selection and startup selection at reset
// - same initial-mode choice applies on return from power failure
// - start 0 / mode 0: external start, switching among three only stopped
// - outside start 10, panel to network or back must pass through external mode
// - mode 1: panel mode, every switch request refused
// - start 0 / mode 2: external start, external/network only, no panel
// - mode 3 or 4: combined mode, all switching refused
// - start 0 / mode 6: external start, switching allowed while running
// - start 0 / mode 7 with output stop active: external start, switching allowed only stopped
// - mode 7 with output stop inactive: forced external, switching refused
// - start 1: network start for 0, 2, 6 and 7 with stop active
// - start 10 / mode 0: network start, panel/network switching only
// - start 10 / mode 2: network start, all changes refused
// - start 10 / mode 6 runs switching; mode 7 acts as start 0
// - start 10: panel key or switch input toggles panel/network
// - both settings writable in every mode despite write protection
// - startup selection writable only while extended display select is 0
// - net/panel input on selects panel, off selects network, if allowed
// - precedence: mode sel, stop, net/ext, net/panel, ext/panel, startup
package oms_pkg;

  typedef enum logic [1:0] {
    OMS_EXT,
    OMS_PANEL,
    OMS_NET,
    OMS_COMBINED
  } oms_mode_t;

  // settings write port carrier
  typedef struct packed {
    logic       mode_we;
    logic [3:0] mode_val;
    logic       start_we;
    logic [3:0] start_val;
  } oms_wr_t;

  localparam logic [3:0] OMS_MODE_RST  = 4'h0;
  localparam logic [3:0] OMS_START_RST = 4'h0;
  localparam logic [3:0] OMS_START_NET = 4'h1;
  localparam logic [3:0] OMS_START_PNS = 4'ha;
  localparam logic [3:0] OMS_SEL_0 = 4'h0;
  localparam logic [3:0] OMS_SEL_1 = 4'h1;
  localparam logic [3:0] OMS_SEL_2 = 4'h2;
  localparam logic [3:0] OMS_SEL_3 = 4'h3;
  localparam logic [3:0] OMS_SEL_4 = 4'h4;
  localparam logic [3:0] OMS_SEL_6 = 4'h6;
  localparam logic [3:0] OMS_SEL_7 = 4'h7;

endpackage

// ---- design/oms_mode_selector.sv ----
`timescale 1ns/1ps
module oms_mode_selector (
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  input  wire oms_pkg::oms_wr_t i_wr,
  input  wire logic             i_ext_display_zero,
  input  wire logic             i_power_restore,
  input  wire logic             i_output_stop_input,
  input  wire logic             i_net_external_switch_input,
  input  wire logic             i_net_panel_switch_input,
  input  wire logic             i_external_panel_switch_input,
  input  wire logic             i_panel_key,
  input  wire logic             i_req_valid,
  input  wire oms_pkg::oms_mode_t i_req_mode,
  input  wire logic             i_running,
  output oms_pkg::oms_mode_t    o_mode,
  output logic [3:0]            o_mode_sel,
  output logic [3:0]            o_start_sel,
  output logic                  o_refused
);
  import oms_pkg::*;

  logic [3:0] mode_sel;
  logic [3:0] start_sel;
  oms_mode_t  mode;
  logic       refused;
  // switch input levels, high bit first: net/ext, net/panel, ext/panel
  logic [2:0] sw_lvl;
  // the same levels one clock earlier; a difference is a move request
  logic [2:0] sw_q;
  logic       net_panel_q;
  logic       net_ext_q;
  logic       ext_panel_q;
  logic       started;
  oms_mode_t  next_mode;
  logic       next_refused;

  // initial mode from the two settings and the stop input
  function automatic oms_mode_t init_mode(input logic [3:0] ms,
                                          input logic [3:0] ss,
                                          input logic       stp);
    oms_mode_t m;
    m = OMS_EXT;
    if (ms == OMS_SEL_1)
      m = OMS_PANEL;
    else if (ms == OMS_SEL_3 || ms == OMS_SEL_4)
      m = OMS_COMBINED;
    else if (ms == OMS_SEL_7 && !stp)
      m = OMS_EXT;
    else if (ss == OMS_START_NET)
      m = OMS_NET;
    else if (ss == OMS_START_PNS && ms != OMS_SEL_7)
      m = OMS_NET;
    return m;
  endfunction

  // legal range check for a startup code
  function automatic logic start_ok(input logic [3:0] v);
    return v == OMS_START_RST || v == OMS_START_NET ||
           v == OMS_START_PNS;
  endfunction

  function automatic logic mode_ok(input logic [3:0] v);
    return v <= OMS_SEL_4 || v == OMS_SEL_6 || v == OMS_SEL_7;
  endfunction

  // settings ignore write protection; startup code gated by display select
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      mode_sel <= OMS_MODE_RST;
    else if (i_wr.mode_we && mode_ok(i_wr.mode_val))
      mode_sel <= i_wr.mode_val;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      start_sel <= OMS_START_RST;
    else if (i_wr.start_we && i_ext_display_zero &&
             start_ok(i_wr.start_val))
      start_sel <= i_wr.start_val;
  end

  // switching decision; order of the checks gives the precedence
  always_comb
  begin
    logic pns;
    logic can_sw;
    oms_mode_t want;
    logic has_req;
    pns = (start_sel == OMS_START_PNS) && (mode_sel != OMS_SEL_7);
    can_sw = !i_running || mode_sel == OMS_SEL_6;
    want = mode;
    has_req = 1'b0;
    next_mode = mode;
    next_refused = 1'b0;
    // edge-free panel key acts as a toggle request
    if (pns && i_panel_key)
    begin
      has_req = 1'b1;
      want = (mode == OMS_PANEL) ? OMS_NET : OMS_PANEL;
    end
    else if (pns && i_net_panel_switch_input != net_panel_q)
    begin
      has_req = 1'b1;
      want = i_net_panel_switch_input ? OMS_PANEL : OMS_NET;
    end
    // the net/ext input acts under startup codes 0 and 1, and under 10 with mode 7
    else if (!pns && i_net_external_switch_input != net_ext_q)
    begin
      has_req = 1'b1;
      want = i_net_external_switch_input ? OMS_NET : OMS_EXT;
    end
    // ext/panel input ranks below the other two switch inputs
    else if (!pns && i_external_panel_switch_input != ext_panel_q)
    begin
      has_req = 1'b1;
      want = i_external_panel_switch_input ? OMS_EXT : OMS_PANEL;
    end
    // host requests lose to the panel key and to every switch input that acts in the same cycle
    else if (i_req_valid)
    begin
      has_req = 1'b1;
      want = i_req_mode;
    end
    if (mode_sel == OMS_SEL_1 || mode_sel == OMS_SEL_3 ||
        mode_sel == OMS_SEL_4)
    begin
      next_refused = has_req;
    end
    else if (mode_sel == OMS_SEL_7 && !i_output_stop_input)
    begin
      next_mode = OMS_EXT;
      next_refused = has_req && want != OMS_EXT;
    end
    else if (has_req && want != mode)
    begin
      if (!can_sw || want == OMS_COMBINED)
        next_refused = 1'b1;
      else if (pns)
      begin
        if (mode_sel == OMS_SEL_2 || want == OMS_EXT)
          next_refused = 1'b1;
        else
          next_mode = want;
      end
      else if (mode_sel == OMS_SEL_2 && want == OMS_PANEL)
        next_refused = 1'b1;
      else if (mode != OMS_EXT && want != OMS_EXT)
        next_refused = 1'b1;
      else
        next_mode = want;
    end
  end

  // mode register loads the initial mode on the first edge after reset and on power restore
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      mode <= OMS_EXT;
      started <= 1'b0;
    end
    else if (!started || i_power_restore)
    begin
      mode <= init_mode(mode_sel, start_sel, i_output_stop_input);
      started <= 1'b1;
    end
    else
      mode <= next_mode;
  end

  // switch inputs gathered so one loop can keep their previous levels
  assign sw_lvl = {i_net_external_switch_input,
                   i_net_panel_switch_input,
                   i_external_panel_switch_input};

  // previous level of each switch input, so only changes request a move;
  // a level held across reset is not taken as a change because the
  // first edge after release loads the initial mode instead
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sw_hist
      always_ff @(posedge i_mclk)
      begin
        if (!i_nrst)
          sw_q[gi] <= 1'b0;
        else
          sw_q[gi] <= sw_lvl[gi];
      end
    end
  endgenerate

  // named views of the history bits for the decision logic
  assign net_ext_q   = sw_q[2];
  assign net_panel_q = sw_q[1];
  assign ext_panel_q = sw_q[0];

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      refused <= 1'b0;
    else
      refused <= started && !i_power_restore && next_refused;
  end

  assign o_mode = mode;
  assign o_mode_sel = mode_sel;
  assign o_start_sel = start_sel;
  assign o_refused = refused;

endmodule // oms_mode_selector

// ---- verification/oms_mode_selector_assertions.sv ----
`timescale 1ns/1ps
module oms_mode_selector_chk
  import oms_pkg::*;
(
  input wire logic       i_mclk, i_nrst, i_power_restore, i_panel_key,
  input wire logic       i_ext_display_zero, i_output_stop_input,
  input wire logic       i_req_valid, i_running, o_refused,
  input wire oms_wr_t    i_wr,
  input wire oms_mode_t  i_req_mode, o_mode,
  input wire logic [3:0] o_mode_sel, o_start_sel,
  input wire logic       i_net_external_switch_input,
  input wire logic       i_net_panel_switch_input,
  input wire logic       i_external_panel_switch_input
);
  logic [2:0] sw_q;
  // previous switch levels, so a change counts as a request
  always_ff @(posedge i_mclk)
    sw_q <= {i_net_external_switch_input, i_net_panel_switch_input,
             i_external_panel_switch_input};
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // requests count from the second edge; restore and key take precedence
  sequence s_live;
    $past(i_nrst) && !i_power_restore && !i_panel_key;
  endsequence
  a_stop_walk: assert property (s_live ##0 (o_mode_sel == OMS_SEL_0 &&
    o_start_sel == OMS_START_RST && o_mode == OMS_EXT && i_req_valid &&
    i_req_mode == OMS_NET && !i_running) |=> o_mode == OMS_NET)
    else $error("stopped switch to network not taken");
  a_no_direct: assert property (s_live ##0 (o_start_sel != OMS_START_PNS &&
    o_mode == OMS_PANEL) |=> o_mode != OMS_NET)
    else $error("panel went straight to network");
  a_panel_lock: assert property (s_live ##0 o_mode_sel == OMS_SEL_1
    |=> $stable(o_mode)) else $error("panel lock broken");
  a_no_panel: assert property (s_live ##0 o_mode_sel == OMS_SEL_2
    |=> o_mode != OMS_PANEL) else $error("panel entered in mode 2");
  a_comb_lock: assert property (s_live ##0 (o_mode == OMS_COMBINED &&
    (o_mode_sel == OMS_SEL_3 || o_mode_sel == OMS_SEL_4))
    |=> o_mode == OMS_COMBINED) else $error("combined mode left");
  a_force_ext: assert property (s_live ##0 (o_mode_sel == OMS_SEL_7 &&
    !i_output_stop_input) |=> o_mode == OMS_EXT)
    else $error("external mode not forced");
  a_refuse_cause: assert property (o_refused |-> $past(i_req_valid ||
    i_panel_key || sw_q != {i_net_external_switch_input,
    i_net_panel_switch_input, i_external_panel_switch_input}))
    else $error("refusal without request");
  a_mode_write: assert property (i_wr.mode_we && i_wr.mode_val == OMS_SEL_6
    |=> o_mode_sel == OMS_SEL_6) else $error("mode write lost");
  a_start_gate: assert property (i_wr.start_we && !i_ext_display_zero
    |=> $stable(o_start_sel)) else $error("gated write landed");
endmodule // oms_mode_selector_chk
bind oms_mode_selector oms_mode_selector_chk u_chk (.*);

// ---- verification/oms_host.sv ----
`timescale 1ns/1ps
module oms_host
  import oms_pkg::*;
(
  input  wire logic i_mclk,
  output logic      o_req_valid,
  output oms_mode_t o_req_mode,
  output logic      o_panel_key
);
  // idle outputs; a released mode line shows the inverse, not the old code
  initial
  begin
    o_req_valid = 1'b0;
    o_req_mode = OMS_EXT;
    o_panel_key = 1'b0;
  end
  // host mode request once started up, one cycle long
  task automatic req(input oms_mode_t m);
    @(negedge i_mclk) o_req_valid = 1'b1;
    o_req_mode = m;
    @(negedge i_mclk) o_req_valid = 1'b0;
    o_req_mode = oms_mode_t'(~m);
  endtask
  // panel mode key press
  task automatic key();
    @(negedge i_mclk) o_panel_key = 1'b1;
    @(negedge i_mclk) o_panel_key = 1'b0;
  endtask
endmodule // oms_host

// ---- verification/tb_oms_mode_selector.sv ----
`timescale 1ns/1ps
module tb_oms_mode_selector;
  import oms_pkg::*;
  logic i_mclk = 1'b0, i_nrst = 1'b0, i_ext_display_zero = 1'b1;
  logic i_power_restore = 1'b0, i_output_stop_input = 1'b0, i_running = 1'b0;
  logic i_net_external_switch_input = 1'b0, i_net_panel_switch_input = 1'b0;
  logic i_external_panel_switch_input = 1'b0, i_req_valid, i_panel_key;
  logic o_refused;
  oms_wr_t i_wr = '0;
  oms_mode_t i_req_mode, o_mode;
  logic [3:0] o_mode_sel, o_start_sel;
  int bad_count = 0, cmp_count = 0;
  oms_mode_selector DUT (.*);
  oms_host u_host (.i_mclk(i_mclk), .o_req_valid(i_req_valid),
    .o_req_mode(i_req_mode), .o_panel_key(i_panel_key));
  always #2.5 i_mclk = ~i_mclk;
  task automatic chk(input string n, input logic [3:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  // settings first, then a power return replays the start-up choice
  task automatic boot(input logic [3:0] ms, ss);
    @(negedge i_mclk) i_wr = '{1'b1, ms, 1'b1, ss};
    @(negedge i_mclk) i_wr = '0;
    i_power_restore = 1'b1;
    @(negedge i_mclk) i_power_restore = 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence; expectations come from the start-up table
  initial
  begin
    repeat (3) @(negedge i_mclk);
    i_nrst = 1'b1;
    chk("reset mode", o_mode, OMS_EXT);
    i_ext_display_zero = 1'b0;
    @(negedge i_mclk) i_wr = '{1'b0, 4'h0, 1'b1, OMS_START_NET};
    @(negedge i_mclk) i_wr = '{1'b0, 4'h0, 1'b0, 4'h0};
    chk("gated start", o_start_sel, OMS_START_RST);
    i_ext_display_zero = 1'b1;
    boot(OMS_SEL_0, 4'h5);
    chk("bad start code", o_start_sel, OMS_START_RST);
    u_host.req(OMS_NET);
    chk("ext to net", o_mode, OMS_NET);
    u_host.req(OMS_PANEL);
    chk("net to panel", {o_refused, o_mode}, {1'b1, OMS_NET});
    boot(OMS_SEL_1, OMS_START_RST);
    u_host.req(OMS_EXT);
    chk("panel lock", o_mode, OMS_PANEL);
    boot(OMS_SEL_2, OMS_START_RST);
    u_host.req(OMS_PANEL);
    chk("mode 2 panel", o_mode, OMS_EXT);
    boot(OMS_SEL_4, OMS_START_PNS);
    chk("combined", o_mode, OMS_COMBINED);
    i_running = 1'b1;
    boot(OMS_SEL_6, OMS_START_RST);
    u_host.req(OMS_PANEL);
    chk("running switch", o_mode, OMS_PANEL);
    i_running = 1'b0;
    i_output_stop_input = 1'b1;
    boot(OMS_SEL_7, OMS_START_RST);
    u_host.req(OMS_NET);
    chk("mode 7 stop on", o_mode, OMS_NET);
    i_output_stop_input = 1'b0;
    @(negedge i_mclk) chk("mode 7 forced", o_mode, OMS_EXT);
    boot(OMS_SEL_6, OMS_START_NET);
    chk("start 1 net", o_mode, OMS_NET);
    boot(OMS_SEL_0, OMS_START_PNS);
    chk("start 10 net", o_mode, OMS_NET);
    u_host.key();
    chk("panel key", o_mode, OMS_PANEL);
    u_host.key();
    chk("panel key back", o_mode, OMS_NET);
    i_net_panel_switch_input = 1'b1;
    @(negedge i_mclk) chk("switch input", o_mode, OMS_PANEL);
    u_host.req(OMS_EXT);
    chk("start 10 no ext", {o_refused, o_mode}, {1'b1, OMS_PANEL});
    boot(OMS_SEL_2, OMS_START_PNS);
    u_host.req(OMS_EXT);
    chk("start 10 fixed", o_mode, OMS_NET);
    boot(OMS_SEL_7, OMS_START_PNS);
    chk("start 10 mode 7", o_mode, OMS_EXT);
    print_verdict();
  end
  // watchdog well beyond the 67 cycles the sequence needs
  initial
  begin
    #20000;
    bad_count++;
    print_verdict();
  end
endmodule // tb_oms_mode_selector
